// ===== hdl/rdst_sleep_ctrl.sv
// Deep-sleep controller: register bank, sleep timer, wake interrupt and wake sequencing.
//
// Notes on behaviour
// - External wake request wakes the core unless the external wake disable bit is set.
// - Sleep status reads 1 while the core is in deep sleep and through the wake cycle that follows.
// - Writing 1 to software wake request wakes a sleeping core; reads as 0.
// - Writing 1 to correction enable after wake loads and restarts counters; reads 0.
// - Sleep request asks for deep sleep; cleared when sleep status falls.
// - Sleep time gives low-power cycles spent asleep before automatic wake.
// - Sleep time of zero sleeps forever until a wake request arrives.
// - Duration counter clears at sleep start, counts low-power cycles, then holds.
// - After external wake, interrupt drops when the external delay has elapsed.
// - Wake interrupt rises when the timer is the set lead short of expiry.
// - Wake interrupt drops when the timer is the release lead short of expiry.
// - Micro correction register holds the phase loaded into the fine counter.
// - Slot correction register holds the value loaded into the slot counter.
// - Fine counter counts microseconds within each 625 microsecond slot.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module rdst_sleep_ctrl
  import rdst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic lp_clk,
  input wire logic external_wake_request,
  output logic low_power_wake_interrupt,
  output logic core_clock_run,
  output logic irq,
  output logic [MICRO_W-1:0] microsecond_counter,
  output logic [SLOT_W-1:0] slot_counter
);

  typedef struct packed {
    rdst_state_t st;
    logic external_wake_disable;
    logic [IRQ_EN_W-1:0] irq_en;
    logic sleep_req;
    logic [31:0] sleep_time_target;
    logic [31:0] sleep_duration_measured;
    logic [EXT_DELAY_W-1:0] ext_delay;
    logic [SET_LEAD_W-1:0] set_lead;
    logic [REL_LEAD_W-1:0] rel_lead;
    logic [MICRO_W-1:0] micro_corr;
    logic [SLOT_W-1:0] slot_corr;
    logic woke;
    logic tb_run;
    logic tb_load;
    logic clk_run;
    logic lp_q;
    logic wake_irq;
    logic ext_active;
    logic [EXT_DELAY_W-1:0] ext_cnt;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic [31:0] rd_data;
  } rdst_ctrl_state_t;

  rdst_ctrl_state_t s_q;
  rdst_ctrl_state_t s_d;

  rdst_time_if tif ();

  rdst_timebase u_timebase (
    .sys_clk(sys_clk),
    .srst(srst),
    .tif(tif)
  );

  logic lp_tick;
  logic sleep_stat;
  logic wr_ctrl;
  logic ext_accept;
  logic soft_wake;
  logic timer_expire;
  logic timed_sleep;
  logic [31:0] dur_next;
  logic [31:0] remaining;
  logic [EV_W-1:0] ev_set;
  logic [31:0] rd_value;

  // The low-power clock is taken as synchronous, so one register suffices for its edge.
  assign lp_tick = lp_clk & ~s_q.lp_q;

  // Status stays high through the wake cycle so the clock is back before it falls.
  assign sleep_stat = (s_q.st == ST_ASLEEP) || (s_q.st == ST_WAKE);

  assign wr_ctrl = wr_en && (addr == ADDR_CONTROL);
  assign soft_wake = wr_ctrl && wr_data[CTL_SOFT_WAKE_BIT] && (s_q.st == ST_ASLEEP);
  assign ext_accept = external_wake_request && !s_q.external_wake_disable && (s_q.st == ST_ASLEEP);
  assign dur_next = 32'(s_q.sleep_duration_measured + 32'h1);
  assign timed_sleep = (s_q.sleep_time_target != REG_RESET);
  assign timer_expire = (s_q.st == ST_ASLEEP) && lp_tick && timed_sleep &&
                        (dur_next == s_q.sleep_time_target);
  assign remaining = 32'(s_q.sleep_time_target - s_q.sleep_duration_measured);

  always_comb begin
    rd_value = REG_RESET;
    if (addr == ADDR_CONTROL) begin
      rd_value[CTL_EXT_DIS_BIT] = s_q.external_wake_disable;
      rd_value[CTL_SLEEP_STAT_BIT] = sleep_stat;
      rd_value[CTL_SLEEP_REQ_BIT] = s_q.sleep_req;
      rd_value[CTL_IRQ_EN_LSB +: IRQ_EN_W] = s_q.irq_en;
    end else if (addr == ADDR_SLEEP_TIME) begin
      rd_value = s_q.sleep_time_target;
    end else if (addr == ADDR_SLEEP_DUR) begin
      rd_value = s_q.sleep_duration_measured;
    end else if (addr == ADDR_LEAD_TIMES) begin
      rd_value[EXT_DELAY_LSB +: EXT_DELAY_W] = s_q.ext_delay;
      rd_value[SET_LEAD_LSB +: SET_LEAD_W] = s_q.set_lead;
      rd_value[REL_LEAD_LSB +: REL_LEAD_W] = s_q.rel_lead;
    end else if (addr == ADDR_MICRO_CORR) begin
      rd_value[MICRO_W-1:0] = s_q.micro_corr;
    end else if (addr == ADDR_SLOT_CORR) begin
      rd_value[SLOT_W-1:0] = s_q.slot_corr;
    end else if (addr == ADDR_EVENT_STATUS) begin
      rd_value[EV_W-1:0] = s_q.ev_status;
    end else if (addr == ADDR_EVENT_MASK) begin
      rd_value[EV_W-1:0] = s_q.ev_mask;
    end
  end

  always_comb begin
    s_d = s_q;
    ev_set = '0;
    s_d.lp_q = lp_clk;
    s_d.tb_load = 1'b0;
    s_d.rd_data = rd_en ? rd_value : REG_RESET;

    // Register writes.
    if (wr_en) begin
      if (addr == ADDR_CONTROL) begin
        s_d.external_wake_disable = wr_data[CTL_EXT_DIS_BIT];
        s_d.irq_en = wr_data[CTL_IRQ_EN_LSB +: IRQ_EN_W];
        s_d.sleep_req = wr_data[CTL_SLEEP_REQ_BIT];
        if (wr_data[CTL_CORR_EN_BIT] && s_q.woke) begin
          s_d.tb_load = 1'b1;
          s_d.tb_run = 1'b1;
          s_d.woke = 1'b0;
        end
      end else if (addr == ADDR_SLEEP_TIME) begin
        s_d.sleep_time_target = wr_data;
      end else if (addr == ADDR_LEAD_TIMES) begin
        s_d.ext_delay = wr_data[EXT_DELAY_LSB +: EXT_DELAY_W];
        s_d.set_lead = wr_data[SET_LEAD_LSB +: SET_LEAD_W];
        s_d.rel_lead = wr_data[REL_LEAD_LSB +: REL_LEAD_W];
      end else if (addr == ADDR_MICRO_CORR) begin
        s_d.micro_corr = wr_data[MICRO_W-1:0];
      end else if (addr == ADDR_SLOT_CORR) begin
        s_d.slot_corr = wr_data[SLOT_W-1:0];
      end else if (addr == ADDR_EVENT_MASK) begin
        s_d.ev_mask = wr_data[EV_W-1:0];
      end
    end

    // Sleep sequencing.
    case (s_q.st)
      ST_ACTIVE: begin
        if (s_q.sleep_req) begin
          s_d.st = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // Entry waits for a low-power edge so the duration count starts on a whole cycle.
        if (!s_d.sleep_req) begin
          s_d.st = ST_ACTIVE;
        end else if (lp_tick) begin
          s_d.st = ST_ASLEEP;
          s_d.sleep_duration_measured = REG_RESET;
          s_d.clk_run = 1'b0;
          s_d.tb_run = 1'b0;
          s_d.woke = 1'b0;
          ev_set[EV_ENTER_BIT] = 1'b1;
        end
      end
      ST_ASLEEP: begin
        if (lp_tick) begin
          s_d.sleep_duration_measured = dur_next;
        end
        if (timer_expire) begin
          s_d.st = ST_WAKE;
          s_d.clk_run = 1'b1;
          ev_set[EV_TIMER_WAKE_BIT] = 1'b1;
        end else if (soft_wake || ext_accept) begin
          s_d.st = ST_WAKE;
          s_d.clk_run = 1'b1;
          ev_set[EV_REQ_WAKE_BIT] = 1'b1;
        end
      end
      ST_WAKE: begin
        s_d.st = ST_ACTIVE;
        s_d.sleep_req = 1'b0;
        s_d.woke = 1'b1;
      end
      default: begin
        s_d.st = ST_ACTIVE;
      end
    endcase

    // Wake interrupt from the sleep timer leads.
    if (!s_q.ext_active && sleep_stat && timed_sleep && (s_q.irq_en == IRQ_EN_ALL)) begin
      if (remaining == {22'h0, s_q.rel_lead}) begin
        s_d.wake_irq = 1'b0;
      end else if (remaining == {21'h0, s_q.set_lead}) begin
        s_d.wake_irq = 1'b1;
      end
    end

    // External wake holds the interrupt for the external delay.
    if (ext_accept) begin
      s_d.wake_irq = 1'b1;
      s_d.ext_active = 1'b1;
      s_d.ext_cnt = '0;
    end else if (s_q.ext_active && lp_tick) begin
      if (11'(s_q.ext_cnt + 11'h1) >= s_q.ext_delay) begin
        s_d.wake_irq = 1'b0;
        s_d.ext_active = 1'b0;
      end else begin
        s_d.ext_cnt = 11'(s_q.ext_cnt + 11'h1);
      end
    end

    // A read clears the status, but an event in the same cycle survives.
    if (rd_en && (addr == ADDR_EVENT_STATUS)) begin
      s_d.ev_status = ev_set;
    end else begin
      s_d.ev_status = s_q.ev_status | ev_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= ST_ACTIVE;
      s_q.clk_run <= 1'b1;
      s_q.tb_run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.load = s_q.tb_load;
  assign tif.run = s_q.tb_run;
  assign tif.micro_load = s_q.micro_corr;
  assign tif.slot_load = s_q.slot_corr;

  assign rd_data = s_q.rd_data;
  assign low_power_wake_interrupt = s_q.wake_irq;
  assign core_clock_run = s_q.clk_run;
  assign irq = |(s_q.ev_status & s_q.ev_mask);
  assign microsecond_counter = tif.micro_cnt;
  assign slot_counter = tif.slot_cnt;

endmodule

// ===== hdl/rdst_pkg.sv
// Constants, register map and state types for the deep-sleep timer.
package rdst_pkg;

  // Register byte addresses.
  localparam logic [31:0] ADDR_CONTROL = 32'h4000_0030;
  localparam logic [31:0] ADDR_SLEEP_TIME = 32'h4000_0034;
  localparam logic [31:0] ADDR_SLEEP_DUR = 32'h4000_0038;
  localparam logic [31:0] ADDR_LEAD_TIMES = 32'h4000_003c;
  localparam logic [31:0] ADDR_MICRO_CORR = 32'h4000_0040;
  localparam logic [31:0] ADDR_SLOT_CORR = 32'h4000_0044;
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h4000_0070;
  localparam logic [31:0] ADDR_EVENT_MASK = 32'h4000_0074;

  // Reset value shared by every register.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Control register fields.
  localparam int CTL_EXT_DIS_BIT = 31;
  localparam int CTL_SLEEP_STAT_BIT = 15;
  localparam int CTL_SOFT_WAKE_BIT = 4;
  localparam int CTL_CORR_EN_BIT = 3;
  localparam int CTL_SLEEP_REQ_BIT = 2;
  localparam int CTL_IRQ_EN_LSB = 0;
  localparam int IRQ_EN_W = 2;
  localparam logic [1:0] IRQ_EN_ALL = 2'h3;

  // Lead time fields.
  localparam int EXT_DELAY_LSB = 21;
  localparam int EXT_DELAY_W = 11;
  localparam int SET_LEAD_LSB = 10;
  localparam int SET_LEAD_W = 11;
  localparam int REL_LEAD_LSB = 0;
  localparam int REL_LEAD_W = 10;

  // Correction widths.
  localparam int MICRO_W = 10;
  localparam int SLOT_W = 27;

  // Event status bits.
  localparam int EV_W = 3;
  localparam int EV_ENTER_BIT = 0;
  localparam int EV_TIMER_WAKE_BIT = 1;
  localparam int EV_REQ_WAKE_BIT = 2;

  // Timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MICROSECOND_NS = 1000;
  localparam int US_CYCLES = MICROSECOND_NS / CLK_PERIOD_NS;
  localparam logic [4:0] US_DIV_LAST = 5'(US_CYCLES - 1);
  localparam int SLOT_US = 625;
  localparam logic [MICRO_W-1:0] SLOT_US_LAST = 10'(SLOT_US - 1);

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_ENTER,
    ST_ASLEEP,
    ST_WAKE
  } rdst_state_t;

endpackage

// ===== hdl/rdst_time_if.sv
// Link between the sleep controller and the microsecond and slot timebase.
`timescale 1ns/100ps
interface rdst_time_if;
  logic load;
  logic run;
  logic [9:0] micro_load;
  logic [26:0] slot_load;
  logic [9:0] micro_cnt;
  logic [26:0] slot_cnt;

  modport ctrl (
    output load,
    output run,
    output micro_load,
    output slot_load,
    input micro_cnt,
    input slot_cnt
  );

  modport timebase (
    input load,
    input run,
    input micro_load,
    input slot_load,
    output micro_cnt,
    output slot_cnt
  );
endinterface

// ===== hdl/rdst_timebase.sv
// Microsecond fine counter and slot counter, loadable with correction values.
`timescale 1ns/100ps
module rdst_timebase
  import rdst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  rdst_time_if.timebase tif
);

  typedef struct packed {
    logic [4:0] div;
    logic [MICRO_W-1:0] micro;
    logic [SLOT_W-1:0] slot;
  } rdst_tb_state_t;

  rdst_tb_state_t s_q;
  rdst_tb_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (tif.load) begin
      s_d.div = 5'h00;
      s_d.micro = tif.micro_load;
      s_d.slot = tif.slot_load;
    end else if (tif.run) begin
      if (s_q.div >= US_DIV_LAST) begin
        s_d.div = 5'h00;
        // A loaded phase beyond the slot end still wraps rather than running on.
        if (s_q.micro >= SLOT_US_LAST) begin
          s_d.micro = 10'h000;
          s_d.slot = 27'(s_q.slot + 27'h1);
        end else begin
          s_d.micro = 10'(s_q.micro + 10'h1);
        end
      end else begin
        s_d.div = 5'(s_q.div + 5'h01);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.micro_cnt = s_q.micro;
  assign tif.slot_cnt = s_q.slot;

endmodule

// ===== verif/rdst_checker.sv
// Port assertions for the deep-sleep controller.
`timescale 1ns/100ps
module rdst_checker
  import rdst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic lp_clk,
  input wire logic external_wake_request,
  input wire logic low_power_wake_interrupt,
  input wire logic core_clock_run,
  input wire logic irq,
  input wire logic [MICRO_W-1:0] microsecond_counter,
  input wire logic [SLOT_W-1:0] slot_counter
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not idle");
  wo_bits_a: assert property ($past(rd_en) && $past(addr) == ADDR_CONTROL |-> rd_data[4:3] == 2'h0)
    else $error("write-only bits read back");
  stat_sleep_a: assert property ($past(rd_en) && $past(addr) == ADDR_CONTROL && !$past(core_clock_run)
    |-> rd_data[15])
    else $error("sleep status low while asleep");
  irq_asleep_a: assert property ($rose(low_power_wake_interrupt) |-> !$past(core_clock_run))
    else $error("wake interrupt while awake");
  irq_drop_a: assert property ($fell(low_power_wake_interrupt) |-> $past(lp_clk))
    else $error("wake interrupt dropped off lp edge");
  stop_cause_a: assert property ($fell(core_clock_run) |-> $past(lp_clk))
    else $error("clock stopped off lp edge");
  restart_cause_a: assert property ($rose(core_clock_run) |->
    $past(lp_clk) || $past(wr_en) || $past(external_wake_request) || $past(external_wake_request, 2))
    else $error("clock restarted without cause");
  fine_range_a: assert property (microsecond_counter <= SLOT_US_LAST)
    else $error("fine counter out of range");
  fine_step_a: assert property ($changed(microsecond_counter) |->
    microsecond_counter == $past(microsecond_counter) + 10'h1
    || microsecond_counter == 10'h0 || $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3))
    else $error("fine counter jumped");
  cover property ($fell(core_clock_run));
  cover property ($rose(low_power_wake_interrupt));
  cover property ($rose(irq));
endmodule
bind rdst_sleep_ctrl rdst_checker chk (.sys_clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .lp_clk,
  .external_wake_request, .low_power_wake_interrupt, .core_clock_run, .irq, .microsecond_counter, .slot_counter);

// ===== verif/rdst_sleep_ctrl_bench.sv
// Self-checking bench for the deep-sleep controller.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module rdst_sleep_ctrl_bench;
  import rdst_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic lp_clk = 1'b0;
  logic lp_prev = 1'b0;
  logic ext_req = 1'b0;
  logic [2:0] lp_cnt = 3'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic wake_irq, clk_run, irq;
  logic [MICRO_W-1:0] micro;
  logic [SLOT_W-1:0] slot;
  int bad_count = 0;
  int checked = 0;
  int lp_edges = 0;
  int a, b;
  logic [31:0] rows [7][3] = '{'{ADDR_SLEEP_TIME, 32'hffff_ffff, 32'hffff_ffff},
    '{ADDR_LEAD_TIMES, 32'hffff_ffff, 32'hffff_ffff}, '{ADDR_MICRO_CORR, 32'hffff_ffff, 32'h0000_03ff},
    '{ADDR_SLOT_CORR, 32'hffff_ffff, 32'h07ff_ffff}, '{ADDR_CONTROL, 32'h8000_001b, 32'h8000_0003},
    '{ADDR_SLEEP_DUR, 32'hffff_ffff, 32'h0}, '{32'h4000_0048, 32'hffff_ffff, 32'h0}};
  rdst_sleep_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .lp_clk(lp_clk), .external_wake_request(ext_req),
    .low_power_wake_interrupt(wake_irq), .core_clock_run(clk_run), .irq(irq), .microsecond_counter(micro),
    .slot_counter(slot));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // The low-power clock runs free at one eighth of the system clock.
  always @(posedge sys_clk) begin
    lp_cnt <= lp_cnt + 3'h1;
    lp_clk <= lp_cnt[2];
    lp_prev <= lp_clk;
    if (lp_clk && !lp_prev) lp_edges <= lp_edges + 1;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    addr <= ad;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] e, input string nm);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, e, rd_data)
    @(posedge sys_clk);
  endtask
  task automatic wait_sig(input bit sel, input logic val);
    int n;
    n = 0;
    while ((sel ? wake_irq : clk_run) !== val) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        bad_count++;
        end_sim();
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    `CHK("reset clock run", 1'b1, clk_run)
    for (int i = 0; i < 7; i++) rd(rows[i][0], 32'h0, "reset value");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2], "register");
    end
    $display("registers done");
    wr(ADDR_SLEEP_TIME, 32'd20);
    wr(ADDR_LEAD_TIMES, 32'h0080_0c01);
    wr(ADDR_MICRO_CORR, 32'h5);
    wr(ADDR_SLOT_CORR, 32'h123);
    wr(ADDR_EVENT_MASK, 32'h7);
    wr(ADDR_CONTROL, 32'h7);
    wait_sig(0, 1'b0);
    rd(ADDR_CONTROL, 32'h0000_8007, "asleep control");
    wr(ADDR_EVENT_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_EVENT_MASK, 32'h7);
    `CHK("irq unmasked", 1'b1, irq)
    wait_sig(1, 1'b1);
    a = lp_edges;
    wait_sig(1, 1'b0);
    b = lp_edges;
    `CHK("set to release", 2, b - a)
    wait_sig(0, 1'b1);
    `CHK("release to wake", 1, lp_edges - b)
    repeat (2) @(posedge sys_clk);
    rd(ADDR_CONTROL, 32'h3, "woken control");
    rd(ADDR_SLEEP_DUR, 32'd20, "duration");
    rd(ADDR_EVENT_STATUS, 32'h3, "timer events");
    rd(ADDR_EVENT_STATUS, 32'h0, "events cleared");
    `CHK("irq cleared", 1'b0, irq)
    wr(ADDR_CONTROL, 32'hb);
    repeat (2) @(posedge sys_clk);
    `CHK("slot load", 27'h123, slot)
    `CHK("micro load", 1'b1, micro == 10'h5 || micro == 10'h6)
    $display("timed sleep done");
    wr(ADDR_SLEEP_TIME, 32'h0);
    wr(ADDR_CONTROL, 32'h7);
    wait_sig(0, 1'b0);
    repeat (400) @(posedge sys_clk);
    `CHK("infinite sleep", 1'b0, clk_run)
    `CHK("no timed irq", 1'b0, wake_irq)
    wr(ADDR_CONTROL, 32'h17);
    wait_sig(0, 1'b1);
    rd(ADDR_EVENT_STATUS, 32'h5, "soft events");
    $display("soft wake done");
    wr(ADDR_CONTROL, 32'h8000_0007);
    wait_sig(0, 1'b0);
    ext_req <= 1'b1;
    repeat (100) @(posedge sys_clk);
    `CHK("ext disabled", 1'b0, clk_run)
    a = lp_edges;
    wr(ADDR_CONTROL, 32'h7);
    wait_sig(0, 1'b1);
    `CHK("ext irq", 1'b1, wake_irq)
    wait_sig(1, 1'b0);
    `CHK("ext release", 1'b1, lp_edges - a == 4 || lp_edges - a == 5)
    ext_req <= 1'b0;
    rd(ADDR_EVENT_STATUS, 32'h5, "ext events");
    $display("external wake done");
    wr(ADDR_CONTROL, 32'h7);
    wr(ADDR_CONTROL, 32'h3);
    repeat (20) @(posedge sys_clk);
    `CHK("entry aborted", 1'b1, clk_run)
    rd(ADDR_CONTROL, 32'h3, "aborted control");
    $display("entry abort done");
    wr(ADDR_SLEEP_TIME, 32'd20);
    wr(ADDR_CONTROL, 32'h7);
    wait_sig(1, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    `CHK("mid reset wake irq", 1'b0, wake_irq)
    `CHK("mid reset clock run", 1'b1, clk_run)
    `CHK("mid reset micro", 10'h0, micro)
    `CHK("mid reset slot", 27'h0, slot)
    rd(ADDR_CONTROL, 32'h0, "mid reset control");
    rd(ADDR_SLEEP_DUR, 32'h0, "mid reset duration");
    rd(ADDR_EVENT_STATUS, 32'h0, "mid reset events");
    $display("mid-run reset done");
    end_sim();
  end
endmodule
